// file: design/dram_training_pkg.sv
// constants and carrier types shared by the dq training logic
package dram_training_pkg;

    // =====================================================
    // register bus geometry and register offsets
    localparam int ADDR_W = 4;
    localparam int DATA_W = 8;
    localparam logic [3:0] OFS_PATTERN_LOW = 4'h0;
    localparam logic [3:0] OFS_PATTERN_HIGH = 4'h1;
    localparam logic [3:0] OFS_INVERT_LOWER = 4'h2;
    localparam logic [3:0] OFS_INVERT_UPPER = 4'h3;
    localparam logic [3:0] OFS_MASK_SETPOINT = 4'h4;
    localparam logic [3:0] OFS_IO_CONFIG = 4'h5;
    localparam logic [3:0] OFS_READ_LATENCY = 4'h6;
    localparam logic [3:0] OFS_WRITE_LATENCY = 4'h7;
    localparam logic [3:0] OFS_STATUS = 4'h8;

    // =====================================================
    // reset values
    localparam logic [7:0] RST_PATTERN_LOW = 8'h5a;
    localparam logic [7:0] RST_PATTERN_HIGH = 8'h3c;
    localparam logic [7:0] RST_INVERT_LOWER = 8'h55;
    localparam logic [7:0] RST_INVERT_UPPER = 8'h55;
    localparam logic [7:0] RST_MASK_SETPOINT = 8'h20;
    localparam logic [7:0] RST_IO_CONFIG = 8'h00;
    localparam logic [7:0] RST_READ_LATENCY = 8'h06;
    localparam logic [7:0] RST_WRITE_LATENCY = 8'h04;

    // =====================================================
    // field positions
    localparam int DM_DISABLE_BIT = 5;
    localparam int WR_BUS_INV_BIT = 7;
    localparam int RD_BUS_INV_BIT = 6;
    localparam int OPERAND_ENABLE_BIT = 6;

    // =====================================================
    // training select codes in operand bits 5..0
    localparam logic [5:0] SEL_READ_FIFO = 6'h01;
    localparam logic [5:0] SEL_WRITE_FIFO = 6'h07;
    localparam logic [5:0] SEL_READ_CAL = 6'h03;

    // =====================================================
    // fifo and burst geometry
    localparam int FIFO_DEPTH = 5;
    localparam logic [2:0] SLOT_LAST = 3'h4;
    localparam int BURST_LEN = 16;
    localparam logic [3:0] BEAT_LAST = 4'hf;

    // =====================================================
    // commands and states
    typedef enum logic [2:0] {
        CMD_NONE = 3'b000,
        CMD_MULTI = 3'b001,
        CMD_CAS2 = 3'b010,
        CMD_WRITE = 3'b011,
        CMD_MASKED_WRITE = 3'b100,
        CMD_READ = 3'b101,
        CMD_REG_READ = 3'b110,
        CMD_OTHER = 3'b111
    } cmd_kind_type;

    typedef enum logic [1:0] {
        PEND_NONE = 2'b00,
        PEND_READ_FIFO = 2'b01,
        PEND_WRITE_FIFO = 2'b10,
        PEND_READ_CAL = 2'b11
    } pending_type;

    typedef enum logic [1:0] {
        ENG_IDLE = 2'b00,
        ENG_WAIT = 2'b01,
        ENG_BURST = 2'b10
    } engine_state_type;

    typedef struct packed {
        cmd_kind_type kind;
        logic [6:0] operand;
    } cmd_type;

    typedef struct packed {
        logic [1:0] mask_inversion_pin;
        logic [15:0] dq;
    } beat_type;

endpackage

// file: design/dram_dq_training_logic.sv
// dram-side read calibration and write training fifo logic
//
// Overview of operation
// RQ1: one calibration command drives pattern on all lanes
// RQ2: low pattern byte first, after read latency
// RQ3: each byte sent least significant bit first
// RQ4: lower mask to pins 0-7, upper to 8-15
// RQ5: invert masked data pins, never mask pins
// RQ6: mask pins float only if all three disabled
// RQ7: no bus inversion on calibration output
// RQ8: controller waits extra delay after power-down exit
// RQ9: multi purpose command with bit six low: nop
// RQ10: bit six high decodes training select operands
// RQ11: controller follows training command with second column
// RQ12: controller drives second column operands low
// RQ13: fifo write uses write latency from second edge
// RQ14: fifo read uses read latency from second edge
// RQ15: fifo holds five bursts of sixteen beats
// RQ16: fifo reads keep data until overwritten
// RQ17: unwritten slots return legal but undefined data
// RQ18: read pointer steps slots zero to four, wraps
// RQ19: controller limits mode writes between write and read
// RQ20: controller centres eye comparing fifo readback
// RQ21: write and read pointers advance per command
// RQ22: pointers reset at reset and power-down entries
// RQ23: each slot stores sixteen beats per pin
`timescale 1ns/1ps
`default_nettype none

module dram_dq_training_logic (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic [3:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    input wire dram_training_pkg::cmd_type cmd,
    input wire logic pd_entry,
    input wire logic srpd_entry,
    input wire dram_training_pkg::beat_type wr_beat,
    output dram_training_pkg::beat_type rd_beat,
    output logic [15:0] dq_oe_n,
    output logic [1:0] dmi_oe_n
);

    // =====================================================
    // register file
    logic [7:0] pattern_low_q;
    logic [7:0] pattern_high_q;
    logic [7:0] invert_lower_q;
    logic [7:0] invert_upper_q;
    logic [7:0] mask_setpoint_q;
    logic [7:0] io_config_q;
    logic [7:0] read_latency_q;
    logic [7:0] write_latency_q;
    logic [7:0] reg_rdata_q;
    logic [7:0] rdata_d;
    logic [7:0] status_word;

    // write enables, one per register
    wire we_pat_low = reg_wr && (reg_addr == dram_training_pkg::OFS_PATTERN_LOW);
    wire we_pat_high = reg_wr && (reg_addr == dram_training_pkg::OFS_PATTERN_HIGH);
    wire we_inv_low = reg_wr && (reg_addr == dram_training_pkg::OFS_INVERT_LOWER);
    wire we_inv_high = reg_wr && (reg_addr == dram_training_pkg::OFS_INVERT_UPPER);
    wire we_mask = reg_wr && (reg_addr == dram_training_pkg::OFS_MASK_SETPOINT);
    wire we_io = reg_wr && (reg_addr == dram_training_pkg::OFS_IO_CONFIG);
    wire we_rl = reg_wr && (reg_addr == dram_training_pkg::OFS_READ_LATENCY);
    wire we_wl = reg_wr && (reg_addr == dram_training_pkg::OFS_WRITE_LATENCY);

    // pattern and mask registers
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            pattern_low_q <= dram_training_pkg::RST_PATTERN_LOW;
            pattern_high_q <= dram_training_pkg::RST_PATTERN_HIGH;
            invert_lower_q <= dram_training_pkg::RST_INVERT_LOWER;
            invert_upper_q <= dram_training_pkg::RST_INVERT_UPPER;
        end else begin
            if (we_pat_low) pattern_low_q <= reg_wdata;
            if (we_pat_high) pattern_high_q <= reg_wdata;
            if (we_inv_low) invert_lower_q <= reg_wdata;
            if (we_inv_high) invert_upper_q <= reg_wdata;
        end
    end

    // configuration and latency registers
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            mask_setpoint_q <= dram_training_pkg::RST_MASK_SETPOINT;
            io_config_q <= dram_training_pkg::RST_IO_CONFIG;
            read_latency_q <= dram_training_pkg::RST_READ_LATENCY;
            write_latency_q <= dram_training_pkg::RST_WRITE_LATENCY;
        end else begin
            if (we_mask) mask_setpoint_q <= reg_wdata;
            if (we_io) io_config_q <= reg_wdata;
            if (we_rl) read_latency_q <= reg_wdata;
            if (we_wl) write_latency_q <= reg_wdata;
        end
    end

    // =====================================================
    // command decode
    // a training command only counts when the very next command is the
    // second column command; anything else in between drops it
    dram_training_pkg::pending_type pend_q;
    dram_training_pkg::pending_type pend_d;
    wire is_mpc = (cmd.kind == dram_training_pkg::CMD_MULTI);
    wire is_cas2 = (cmd.kind == dram_training_pkg::CMD_CAS2);
    wire is_plain_read = (cmd.kind == dram_training_pkg::CMD_READ);
    wire mpc_active = is_mpc && cmd.operand[dram_training_pkg::OPERAND_ENABLE_BIT]; // RQ9
    wire [5:0] train_sel = cmd.operand[5:0];
    wire sel_rd_fifo = mpc_active && (train_sel == dram_training_pkg::SEL_READ_FIFO); // RQ10
    wire sel_wr_fifo = mpc_active && (train_sel == dram_training_pkg::SEL_WRITE_FIFO); // RQ10
    wire sel_rd_cal = mpc_active && (train_sel == dram_training_pkg::SEL_READ_CAL); // RQ10

    // reserved select codes leave nothing pending
    assign pend_d = sel_rd_fifo ? dram_training_pkg::PEND_READ_FIFO :
                    sel_wr_fifo ? dram_training_pkg::PEND_WRITE_FIFO :
                    sel_rd_cal ? dram_training_pkg::PEND_READ_CAL :
                    dram_training_pkg::PEND_NONE;

    always_ff @(posedge clk) begin
        if (sys_rst) pend_q <= dram_training_pkg::PEND_NONE;
        else pend_q <= pend_d;
    end

    // =====================================================
    // engine starts and fifo pointers
    dram_training_pkg::engine_state_type rd_state_q;
    dram_training_pkg::engine_state_type wr_state_q;
    logic [2:0] wr_ptr_q;
    logic [2:0] rd_ptr_q;
    logic [2:0] wr_ptr_d;
    logic [2:0] rd_ptr_d;

    wire rd_idle = (rd_state_q == dram_training_pkg::ENG_IDLE);
    wire wr_idle = (wr_state_q == dram_training_pkg::ENG_IDLE);
    wire start_rd_fifo = is_cas2 && (pend_q == dram_training_pkg::PEND_READ_FIFO) && rd_idle;
    wire start_rd_cal = is_cas2 && (pend_q == dram_training_pkg::PEND_READ_CAL) && rd_idle;
    wire start_wr_fifo = is_cas2 && (pend_q == dram_training_pkg::PEND_WRITE_FIFO) && wr_idle;
    wire ptr_clear = pd_entry || srpd_entry; // RQ22
    wire [2:0] wr_ptr_inc = (wr_ptr_q == dram_training_pkg::SLOT_LAST) ? 3'h0 : wr_ptr_q + 3'h1;
    wire [2:0] rd_ptr_inc = (rd_ptr_q == dram_training_pkg::SLOT_LAST) ? 3'h0 : rd_ptr_q + 3'h1;

    // a plain array read moves both pointers so they stay in step
    assign wr_ptr_d = ptr_clear ? 3'h0 :
                      (start_wr_fifo || is_plain_read) ? wr_ptr_inc : wr_ptr_q; // RQ21
    assign rd_ptr_d = ptr_clear ? 3'h0 :
                      (start_rd_fifo || is_plain_read) ? rd_ptr_inc : rd_ptr_q; // RQ18

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            wr_ptr_q <= 3'h0; // RQ22
            rd_ptr_q <= 3'h0; // RQ22
        end else begin
            wr_ptr_q <= wr_ptr_d;
            rd_ptr_q <= rd_ptr_d;
        end
    end

    // =====================================================
    // read engine: latency wait then sixteen beats
    // a start while the engine is busy is ignored, so seamless
    // back-to-back reads are not possible at any read latency
    logic [7:0] rd_wait_q;
    logic [3:0] rd_beat_q;
    logic rd_is_cal_q;
    logic [2:0] rd_slot_q;

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            rd_state_q <= dram_training_pkg::ENG_IDLE;
            rd_wait_q <= 8'h00;
            rd_beat_q <= 4'h0;
            rd_is_cal_q <= 1'b0;
            rd_slot_q <= 3'h0;
        end else begin
            unique case (rd_state_q)
                dram_training_pkg::ENG_IDLE: begin
                    if (start_rd_fifo || start_rd_cal) begin
                        rd_state_q <= dram_training_pkg::ENG_WAIT;
                        rd_wait_q <= read_latency_q; // RQ14 RQ2
                        rd_is_cal_q <= start_rd_cal;
                        rd_slot_q <= rd_ptr_q;
                    end
                end
                dram_training_pkg::ENG_WAIT: begin
                    if (rd_wait_q == 8'h00) begin
                        rd_state_q <= dram_training_pkg::ENG_BURST;
                        rd_beat_q <= 4'h0;
                    end else begin
                        rd_wait_q <= rd_wait_q - 8'h01;
                    end
                end
                dram_training_pkg::ENG_BURST: begin
                    rd_beat_q <= rd_beat_q + 4'h1;
                    if (rd_beat_q == dram_training_pkg::BEAT_LAST) begin
                        rd_state_q <= dram_training_pkg::ENG_IDLE;
                    end
                end
                default: rd_state_q <= dram_training_pkg::ENG_IDLE;
            endcase
        end
    end

    // =====================================================
    // write engine: latency wait then capture sixteen beats
    logic [7:0] wr_wait_q;
    logic [3:0] wr_beat_q;
    logic [2:0] wr_slot_q;

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            wr_state_q <= dram_training_pkg::ENG_IDLE;
            wr_wait_q <= 8'h00;
            wr_beat_q <= 4'h0;
            wr_slot_q <= 3'h0;
        end else begin
            unique case (wr_state_q)
                dram_training_pkg::ENG_IDLE: begin
                    if (start_wr_fifo) begin
                        wr_state_q <= dram_training_pkg::ENG_WAIT;
                        wr_wait_q <= write_latency_q; // RQ13
                        wr_slot_q <= wr_ptr_q; // RQ23
                    end
                end
                dram_training_pkg::ENG_WAIT: begin
                    if (wr_wait_q == 8'h00) begin
                        wr_state_q <= dram_training_pkg::ENG_BURST;
                        wr_beat_q <= 4'h0;
                    end else begin
                        wr_wait_q <= wr_wait_q - 8'h01;
                    end
                end
                dram_training_pkg::ENG_BURST: begin
                    wr_beat_q <= wr_beat_q + 4'h1;
                    if (wr_beat_q == dram_training_pkg::BEAT_LAST) begin
                        wr_state_q <= dram_training_pkg::ENG_IDLE;
                    end
                end
                default: wr_state_q <= dram_training_pkg::ENG_IDLE;
            endcase
        end
    end

    // =====================================================
    // fifo storage: five slots of sixteen beats per pin
    // cleared at reset so unwritten slots read a legal zero
    dram_training_pkg::beat_type fifo_q [dram_training_pkg::FIFO_DEPTH][dram_training_pkg::BURST_LEN];
    wire wr_capture = (wr_state_q == dram_training_pkg::ENG_BURST);

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            for (int s = 0; s < dram_training_pkg::FIFO_DEPTH; s++) begin
                for (int b = 0; b < dram_training_pkg::BURST_LEN; b++) begin
                    fifo_q[s][b] <= '0; // RQ17
                end
            end
        end else if (wr_capture) begin
            fifo_q[wr_slot_q][wr_beat_q] <= wr_beat; // RQ15 RQ23
        end
    end

    // =====================================================
    // output beat selection
    // calibration ignores the read inversion setting on purpose
    wire [15:0] cal_pattern = {pattern_high_q, pattern_low_q}; // RQ2
    wire cal_bit = cal_pattern[rd_beat_q]; // RQ3
    wire [15:0] invert_map = {invert_upper_q, invert_lower_q}; // RQ4
    wire [15:0] cal_dq = {16{cal_bit}} ^ invert_map; // RQ1 RQ5 RQ7
    wire [1:0] cal_dmi = {2{cal_bit}}; // RQ5
    wire dmi_active = !mask_setpoint_q[dram_training_pkg::DM_DISABLE_BIT]
                      || io_config_q[dram_training_pkg::WR_BUS_INV_BIT]
                      || io_config_q[dram_training_pkg::RD_BUS_INV_BIT]; // RQ6
    dram_training_pkg::beat_type fifo_word;
    dram_training_pkg::beat_type out_word;
    wire rd_driving = (rd_state_q == dram_training_pkg::ENG_BURST);

    // fifo reads never write storage
    assign fifo_word = fifo_q[rd_slot_q][rd_beat_q]; // RQ16
    assign out_word.dq = rd_is_cal_q ? cal_dq : fifo_word.dq;
    assign out_word.mask_inversion_pin = rd_is_cal_q ? cal_dmi : fifo_word.mask_inversion_pin;

    // registered pins
    dram_training_pkg::beat_type out_beat_q;
    logic [15:0] dq_oe_n_q;
    logic [1:0] dmi_oe_n_q;

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            out_beat_q <= '0;
            dq_oe_n_q <= 16'hffff;
            dmi_oe_n_q <= 2'h3;
        end else begin
            out_beat_q <= rd_driving ? out_word : '0;
            dq_oe_n_q <= rd_driving ? 16'h0000 : 16'hffff; // RQ1
            dmi_oe_n_q <= (rd_driving && dmi_active) ? 2'h0 : 2'h3; // RQ6
        end
    end

    assign rd_beat = out_beat_q;
    assign dq_oe_n = dq_oe_n_q;
    assign dmi_oe_n = dmi_oe_n_q;

    // =====================================================
    // register read back
    assign status_word = {!rd_idle, !wr_idle, rd_ptr_q, wr_ptr_q};
    assign rdata_d = (reg_addr == dram_training_pkg::OFS_PATTERN_LOW) ? pattern_low_q :
                     (reg_addr == dram_training_pkg::OFS_PATTERN_HIGH) ? pattern_high_q :
                     (reg_addr == dram_training_pkg::OFS_INVERT_LOWER) ? invert_lower_q :
                     (reg_addr == dram_training_pkg::OFS_INVERT_UPPER) ? invert_upper_q :
                     (reg_addr == dram_training_pkg::OFS_MASK_SETPOINT) ? mask_setpoint_q :
                     (reg_addr == dram_training_pkg::OFS_IO_CONFIG) ? io_config_q :
                     (reg_addr == dram_training_pkg::OFS_READ_LATENCY) ? read_latency_q :
                     (reg_addr == dram_training_pkg::OFS_WRITE_LATENCY) ? write_latency_q :
                     (reg_addr == dram_training_pkg::OFS_STATUS) ? status_word :
                     8'h00;

    // data stands one cycle after the strobe, else zero
    always_ff @(posedge clk) begin
        if (sys_rst) reg_rdata_q <= 8'h00;
        else reg_rdata_q <= reg_rd ? rdata_d : 8'h00;
    end

    assign reg_rdata = reg_rdata_q;

endmodule // dram_dq_training_logic

`default_nettype wire

// file: verif/dq_training_monitor.sv
// assertions on the ports of the dq training logic
`timescale 1ns/1ps
`default_nettype none

module dq_training_monitor (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic [3:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_rdata,
    input wire dram_training_pkg::cmd_type cmd,
    input wire logic pd_entry,
    input wire logic srpd_entry,
    input wire dram_training_pkg::beat_type wr_beat,
    input wire dram_training_pkg::beat_type rd_beat,
    input wire logic [15:0] dq_oe_n,
    input wire logic [1:0] dmi_oe_n
);
    default clocking @(posedge clk);
    endclocking
    default disable iff (sys_rst);

    // ==========
    // shadow state
    logic [15:0] pat_q, inv_q;
    logic [7:0] mset_q, io_q, lat_q;
    logic [5:0] since_q;
    logic [4:0] run_q;
    logic cal_q;
    dram_training_pkg::cmd_type prev_q;

    // start decode; select codes 01 and 03 differ only in bit 1
    wire is_cas = cmd.kind == dram_training_pkg::CMD_CAS2;
    wire arm = prev_q.kind == dram_training_pkg::CMD_MULTI && prev_q.operand[6];
    wire rd_go = arm && is_cas && prev_q.operand[5:2] == 4'h0 && prev_q.operand[0];
    wire hiz = mset_q[5] && !io_q[7] && !io_q[6];
    wire burst = !dq_oe_n[0];
    wire [15:0] lane_bit = {16{pat_q[run_q[3:0]]}};

    // register shadows, cycles since read start, burst length
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            pat_q <= 16'h3c5a;
            inv_q <= 16'h5555;
            mset_q <= 8'h20;
            io_q <= 8'h00;
            lat_q <= 8'h06;
            since_q <= 6'h3f;
            run_q <= 5'h00;
            cal_q <= 1'b0;
            prev_q <= '0;
        end else begin
            prev_q <= cmd;
            if (reg_wr) begin
                case (reg_addr)
                    4'h0: pat_q[7:0] <= reg_wdata;
                    4'h1: pat_q[15:8] <= reg_wdata;
                    4'h2: inv_q[7:0] <= reg_wdata;
                    4'h3: inv_q[15:8] <= reg_wdata;
                    4'h4: mset_q <= reg_wdata;
                    4'h5: io_q <= reg_wdata;
                    4'h6: lat_q <= reg_wdata;
                    default: ;
                endcase
            end
            if (rd_go) begin
                since_q <= 6'h01;
                cal_q <= prev_q.operand[1];
            end else if (since_q != 6'h3f) begin
                since_q <= since_q + 6'h01;
            end
            run_q <= burst ? run_q + 5'h01 : 5'h00;
        end
    end

    // ==========
    // properties
    sequence nop_pair;
        cmd.kind == dram_training_pkg::CMD_MULTI && !cmd.operand[6] && since_q == 6'h3f ##1 is_cas;
    endsequence
    sequence clear_then_status;
        (pd_entry || srpd_entry) ##1 (reg_rd && reg_addr == 4'h8);
    endsequence

    a_lanes_together: assert property (dq_oe_n == 16'h0000 || dq_oe_n == 16'hffff)
        else $error("data lanes not enabled together");
    a_read_latency: assert property ($fell(dq_oe_n[0]) |-> since_q == lat_q[5:0] + 6'h03)
        else $error("read burst not at read latency");
    a_burst_sixteen: assert property ($rose(dq_oe_n[0]) |-> run_q == 5'h10)
        else $error("read burst not sixteen beats");
    a_dmi_float: assert property (burst && cal_q |-> dmi_oe_n == {2{hiz}})
        else $error("mask pin enable wrong");
    a_bit_order: assert property (burst && cal_q |-> rd_beat.dq == (lane_bit ^ inv_q))
        else $error("calibration lane bit wrong");
    a_dmi_uninverted: assert property (burst && cal_q && !hiz |-> rd_beat.mask_inversion_pin == lane_bit[1:0])
        else $error("mask pin pattern wrong");
    a_ptr_clear: assert property (clear_then_status |=> reg_rdata[5:0] == 6'h00)
        else $error("pointers not cleared");
    a_mpc_nop: assert property (nop_pair |=> dq_oe_n[0] [*8] ##1 dq_oe_n[0] [*8])
        else $error("disabled command drove lanes");
    a_rdata_pulse: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
        else $error("read data outside its cycle");
endmodule // dq_training_monitor

bind dram_dq_training_logic dq_training_monitor mon (
    .clk, .sys_rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .cmd,
    .pd_entry, .srpd_entry, .wr_beat, .rd_beat, .dq_oe_n, .dmi_oe_n
);

`default_nettype wire

// file: verif/training_ctrl_model.sv
// memory controller model: command pairs and write bursts
`timescale 1ns/1ps
`default_nettype none

module training_ctrl_model #(
    parameter int WR_LAT = 4
) (
    input wire logic clk,
    output dram_training_pkg::cmd_type cmd,
    output dram_training_pkg::beat_type wr_beat
);
    initial begin
        cmd = '0;
        wr_beat = '0;
    end

    // data of beat k in slot s; neighbouring beats always differ
    function automatic dram_training_pkg::beat_type beat_val(input logic [2:0] s, input logic [3:0] k);
        return '{s[1:0] ^ k[1:0], {k, ~k, 1'b0, s, k ^ {1'b0, s}}};
    endfunction

    // training command, second column on the next cycle
    task automatic pair(input logic [6:0] op);
        cmd <= '{dram_training_pkg::CMD_MULTI, op};
        @(posedge clk);
        cmd <= '{dram_training_pkg::CMD_CAS2, 7'h00};
        @(posedge clk);
        cmd <= '{dram_training_pkg::CMD_NONE, 7'h00};
    endtask

    // fifo write; lanes inverted after so stale data is not held
    task automatic write_burst(input logic [2:0] s);
        pair({1'b1, dram_training_pkg::SEL_WRITE_FIFO});
        repeat (WR_LAT + 1) @(posedge clk);
        for (int k = 0; k < 16; k++) begin
            wr_beat <= beat_val(s, 4'(k));
            @(posedge clk);
        end
        wr_beat <= dram_training_pkg::beat_type'(~wr_beat);
    endtask
endmodule // training_ctrl_model

`default_nettype wire

// file: verif/dram_dq_training_logic_test.sv
// bench for the dq training logic
`timescale 1ns/1ps
`default_nettype none

module dram_dq_training_logic_test;
    logic clk = 1'b0;
    logic sys_rst = 1'b1;
    logic [3:0] reg_addr = 4'h0;
    logic [7:0] reg_wdata = 8'h00;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic pd_entry = 1'b0;
    logic srpd_entry = 1'b0;
    logic [7:0] reg_rdata;
    logic [15:0] dq_oe_n;
    logic [1:0] dmi_oe_n;
    dram_training_pkg::cmd_type cmd;
    dram_training_pkg::beat_type wr_beat, rd_beat;
    int err_count = 0;
    int samples_checked = 0;
    logic [15:0] pat, inv;
    logic [7:0] lat = 8'h02;
    logic [7:0] rst_tab [8];

    always #20 clk = ~clk;

    dram_dq_training_logic dut (.clk, .sys_rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
        .reg_rdata, .cmd, .pd_entry, .srpd_entry, .wr_beat, .rd_beat, .dq_oe_n, .dmi_oe_n);
    training_ctrl_model #(.WR_LAT(int'(dram_training_pkg::RST_WRITE_LATENCY))) ctrl (.clk, .cmd,
        .wr_beat);

    // ==========
    // shared tasks
    task automatic check(input string what, input logic [17:0] seen, input logic [17:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            err_count++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
        @(posedge clk);
    endtask

    // read data stands only the cycle after the strobe
    task automatic rd(input logic [3:0] a, input logic [7:0] exp);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1 check("reg_rdata", reg_rdata, exp);
        @(posedge clk);
    endtask

    // pattern and masks written low byte first, latency beside them
    task automatic load(input logic [31:0] v);
        {pat[7:0], pat[15:8], inv[7:0], inv[15:8]} = v;
        for (int i = 0; i < 4; i++) wr(4'(i), v[31 - 8 * i -: 8]);
        wr(4'h6, lat);
    endtask

    // calibration burst checked beat by beat
    task automatic cal(input logic [1:0] dmi_exp);
        logic b;
        ctrl.pair({1'b1, dram_training_pkg::SEL_READ_CAL});
        repeat (lat + 2) @(posedge clk);
        for (int k = 0; k < 16; k++) begin
            b = pat[k];
            #1 check("cal_dq", rd_beat.dq, {16{b}} ^ inv);
            check("cal_oe", {dmi_oe_n, dq_oe_n}, {dmi_exp, 16'h0000});
            if (dmi_exp == 2'b00) check("cal_dmi", rd_beat.mask_inversion_pin, {b, b});
            @(posedge clk);
        end
        #1 check("oe_after", dq_oe_n, 16'hffff);
        @(posedge clk);
    endtask

    task automatic fifo_read(input logic [2:0] s);
        ctrl.pair({1'b1, dram_training_pkg::SEL_READ_FIFO});
        repeat (lat + 2) @(posedge clk);
        for (int k = 0; k < 16; k++) begin
            #1 check("fifo_beat", rd_beat, ctrl.beat_val(s, 4'(k)));
            @(posedge clk);
        end
    endtask

    // status low six bits hold both pointers
    task automatic status(input logic [2:0] rp, input logic [2:0] wp);
        repeat (2) @(posedge clk);
        rd(4'h8, {2'b00, rp, wp});
    endtask

    task automatic wrap_up();
        $display("checks %0d mismatches %0d", samples_checked, err_count);
        if (err_count == 0 && samples_checked > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    // ==========
    // main sequence
    initial begin
        rst_tab = '{dram_training_pkg::RST_PATTERN_LOW, dram_training_pkg::RST_PATTERN_HIGH,
            dram_training_pkg::RST_INVERT_LOWER, dram_training_pkg::RST_INVERT_UPPER,
            dram_training_pkg::RST_MASK_SETPOINT, dram_training_pkg::RST_IO_CONFIG,
            dram_training_pkg::RST_READ_LATENCY, dram_training_pkg::RST_WRITE_LATENCY};
        repeat (4) @(posedge clk);
        sys_rst <= 1'b0;
        // reset values, unmapped index, read-only status
        for (int i = 0; i < 8; i++) rd(4'(i), rst_tab[i]);
        rd(4'hf, 8'h00);
        wr(4'h8, 8'hff);
        status(3'h0, 3'h0);
        // disabled and reserved commands leave lanes released
        ctrl.pair({1'b0, dram_training_pkg::SEL_READ_CAL});
        ctrl.pair({1'b1, 6'h3f});
        repeat (30) begin
            @(posedge clk);
            #1 check("idle_oe", dq_oe_n, 16'hffff);
        end
        @(posedge clk);
        // calibration over all mask pin enable settings
        load(32'h1c595555);
        for (int m = 0; m < 8; m++) begin
            wr(4'h4, {2'b00, m[2], 5'h00});
            wr(4'h5, {m[1:0], 6'h00});
            cal(m == 4 ? 2'b11 : 2'b00);
        end
        load(32'h27c3a50f);
        cal(2'b00);
        // five slots written, six reads wrap; no mode writes between
        for (int s = 0; s < 5; s++) ctrl.write_burst(3'(s));
        status(3'h0, 3'h0);
        for (int s = 0; s < 6; s++) fifo_read(3'(s % 5));
        status(3'h1, 3'h0);
        // power-down entries clear both pointers
        ctrl.write_burst(3'h0);
        ctrl.write_burst(3'h1);
        status(3'h1, 3'h2);
        pd_entry <= 1'b1;
        @(posedge clk);
        pd_entry <= 1'b0;
        rd(4'h8, 8'h00);
        fifo_read(3'h0);
        srpd_entry <= 1'b1;
        @(posedge clk);
        srpd_entry <= 1'b0;
        rd(4'h8, 8'h00);
        wrap_up();
    end

    // watchdog: run needs under two thousand cycles
    initial begin
        repeat (5000) @(posedge clk);
        err_count++;
        wrap_up();
    end
endmodule // dram_dq_training_logic_test

`default_nettype wire
